// ==== design/pxc_ext_ctrl_regs.sv ====
// Extended control register bank of a 10/100 PHY, reached over MDC/MDIO.
// Assumes straps are stable at reset release and MDC is slow vs sys_clk.
//
// Summary of operation
// - Polarity inhibit clear lets receiver fix reversed 10Base-T polarity; resets 0.
// - Link loss inhibit set forces 10Base-T link pass; resets 0.
// - Speed source picks control speed bit or live speed pin; reset from strap.
// - Bank select 01 maps vendor words at 0x14 up, else newer words.
// - Twisted-pair tri-state set releases line drivers; resets 0.
// - Automatic power down set lets 100Base-TX power itself down; resets 1.
// - Auto crossover enable resets 1, manual pair assignment resets 0.
`timescale 1ns/1ps
module pxc_ext_ctrl_regs (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic               mdc,
  input  wire logic               mdioIn,
  output logic                    mdioOut,
  output logic                    mdioOe,
  input  wire logic [4:0]         phyAddr,
  input  wire logic               nodeStrap,
  input  wire logic               speedStrap,
  input  wire logic               speedPin,
  input  wire logic               ctrlSpeedBit,
  input  wire logic               remoteFault,
  input  wire logic               linkTestOk,
  input  wire logic               rxPolReversed,
  input  wire logic               rxData10,
  output logic                    rxData10Fixed,
  output logic                    link10Pass,
  output logic                    tpOutEn,
  output logic                    speed100,
  output pxc_pkg::pxc_ctrl_type   ctrlOut
);

  pxc_pkg::pxc_req_type req;
  logic [15:0]          rdData;
  logic [15:0]          ten_reg;
  logic [15:0]          extA_reg;
  logic [15:0]          extB_reg;
  logic [15:0]          newRegs_reg  [pxc_pkg::NEW_DEPTH];
  logic [15:0]          vendRegs_reg [pxc_pkg::VEND_DEPTH];
  logic                 strapDone_reg;
  logic                 rxFixed_reg;
  logic                 linkPass_reg;
  logic                 tpOutEn_reg;
  logic                 speed_reg;
  pxc_pkg::pxc_ctrl_type ctrl_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial management engine
  pxc_mdio_slave u_mdio (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .mdc     (mdc),
    .mdioIn  (mdioIn),
    .phyAddr (phyAddr),
    .rdData  (rdData),
    .mdioOut (mdioOut),
    .mdioOe  (mdioOe),
    .req     (req)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode against the selected bank
  wire logic [1:0] bankSel  = extA_reg[pxc_pkg::EXA_BANK_HI:pxc_pkg::EXA_BANK_LO];
  wire logic       bank1    = bankSel == pxc_pkg::BANK_VENDOR;
  wire logic       hitTen   = req.addr == pxc_pkg::OFF_TENBASE;
  wire logic       hitExtA  = req.addr == pxc_pkg::OFF_EXT_A;
  wire logic       hitExtB  = ~bank1 & (req.addr == pxc_pkg::OFF_EXT_B);
  wire logic       hitNew   = ~bank1 & (req.addr >= pxc_pkg::OFF_NEW_BASE);
  wire logic       hitVend  = bank1 & (req.addr >= pxc_pkg::OFF_VEND_BASE);
  wire logic [4:0] newOff   = req.addr - pxc_pkg::OFF_NEW_BASE;
  wire logic [4:0] vendOff  = req.addr - pxc_pkg::OFF_VEND_BASE;
  wire logic [3:0] newIdx   = newOff[3:0];
  wire logic [3:0] vendIdx  = vendOff[3:0];

  // Readback; read-only fields show live state, reserved bits read zero
  wire logic [15:0] tenRd   = ten_reg & pxc_pkg::TEN_WR_MASK;
  wire logic [15:0] extARd  = (extA_reg & pxc_pkg::EXA_WR_MASK)
                              | ({15'h0000, remoteFault} << pxc_pkg::EXA_RFAULT);
  assign rdData = hitTen  ? tenRd :
                  hitExtA ? extARd :
                  hitExtB ? extB_reg :
                  hitNew  ? newRegs_reg[newIdx] :
                  hitVend ? vendRegs_reg[vendIdx] :
                  pxc_pkg::UNMAPPED;

  // Write data merged under the writable masks
  wire logic [15:0] tenNext  = (req.data & pxc_pkg::TEN_WR_MASK)
                               | (ten_reg & ~pxc_pkg::TEN_WR_MASK);
  wire logic [15:0] extANext = (req.data & pxc_pkg::EXA_WR_MASK)
                               | (extA_reg & ~pxc_pkg::EXA_WR_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Operations and extended control A registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ten_reg       <= pxc_pkg::TEN_RESET;
      extA_reg      <= pxc_pkg::EXA_RESET;
      strapDone_reg <= 1'b0;
    end else begin
      strapDone_reg <= 1'b1;
      if (req.wr && hitTen) begin
        ten_reg <= tenNext;
      end
      if (req.wr && hitExtA) begin
        extA_reg <= extANext;
      end else if (!strapDone_reg) begin
        // Straps caught on the first edge after release, not in reset
        extA_reg[pxc_pkg::EXA_NODE]    <= nodeStrap;
        extA_reg[pxc_pkg::EXA_SPD_SRC] <= speedStrap;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Banked storage; each bank keeps its own words across bank switches
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      extB_reg <= pxc_pkg::EXB_RESET;
      for (int i = 0; i < pxc_pkg::NEW_DEPTH; i++) begin
        newRegs_reg[i] <= pxc_pkg::ARR_RESET;
      end
      for (int i = 0; i < pxc_pkg::VEND_DEPTH; i++) begin
        vendRegs_reg[i] <= pxc_pkg::ARR_RESET;
      end
    end else if (req.wr) begin
      if (hitExtB) begin
        extB_reg <= req.data;
      end
      if (hitNew) begin
        newRegs_reg[newIdx] <= req.data;
      end
      if (hitVend) begin
        vendRegs_reg[vendIdx] <= req.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core-facing controls derived from the fields
  wire logic polCorrect = ~ten_reg[pxc_pkg::TEN_POL_INH];
  wire logic linkInh    = ten_reg[pxc_pkg::TEN_LINK_INH];
  wire logic spdFromPin = extA_reg[pxc_pkg::EXA_SPD_SRC];
  wire logic line_tristate_enable      = extA_reg[pxc_pkg::EXA_TP_TRI];
  pxc_pkg::pxc_ctrl_type ctrlNext;
  assign ctrlNext.polarityCorrectEn    = polCorrect;
  assign ctrlNext.sqeTestInhibit       = ten_reg[pxc_pkg::TEN_SQE_INH];
  assign ctrlNext.linkLossInhibit      = linkInh;
  assign ctrlNext.squelchInhibit       = ten_reg[pxc_pkg::TEN_SQL_INH];
  assign ctrlNext.jabberInhibit        = ten_reg[pxc_pkg::TEN_JAB_INH];
  assign ctrlNext.repeaterMode         = extA_reg[pxc_pkg::EXA_NODE];
  assign ctrlNext.speedFromPin         = spdFromPin;
  assign ctrlNext.lineTristateEnable   = line_tristate_enable;
  assign ctrlNext.autoCrossoverEnable  = extA_reg[pxc_pkg::EXA_XOVER_EN];
  assign ctrlNext.manualPairAssignment = extA_reg[pxc_pkg::EXA_PAIR_MAN];
  assign ctrlNext.autoPowerDown        = extA_reg[pxc_pkg::EXA_AUTO_PD];
  assign ctrlNext.bank1Selected        = bank1;
  assign ctrlNext.ledCtrl              = extB_reg;

  // Datapath effects; one register stage keeps outputs glitch free
  wire logic rxFixedNext = (polCorrect & rxPolReversed) ? ~rxData10 : rxData10;
  wire logic linkNext    = linkInh | linkTestOk;
  wire logic speedNext   = spdFromPin ? speedPin : ctrlSpeedBit;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg     <= '0;
      rxFixed_reg  <= 1'b0;
      linkPass_reg <= 1'b0;
      tpOutEn_reg  <= 1'b0;
      speed_reg    <= 1'b0;
    end else begin
      ctrl_reg     <= ctrlNext;
      rxFixed_reg  <= rxFixedNext;
      linkPass_reg <= linkNext;
      tpOutEn_reg  <= ~line_tristate_enable;
      speed_reg    <= speedNext;
    end
  end

  assign ctrlOut       = ctrl_reg;
  assign rxData10Fixed = rxFixed_reg;
  assign link10Pass    = linkPass_reg;
  assign tpOutEn       = tpOutEn_reg;
  assign speed100      = speed_reg;

endmodule : pxc_ext_ctrl_regs

// ==== shared/pxc_pkg.sv ====
// Constants and carrier types of the extended PHY control register bank.
// Assumes a single management clock domain; MDC is sampled as plain input.
package pxc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Management frame layout
  localparam logic [5:0]  PRE_LEN    = 6'h20;   // Preamble ones before start
  localparam logic [1:0]  OP_READ    = 2'h2;
  localparam logic [1:0]  OP_WRITE   = 2'h1;
  localparam logic [5:0]  OP_LAST    = 6'h01;   // Two opcode bits
  localparam logic [5:0]  ADR_LAST   = 6'h09;   // Ten address bits
  localparam logic [5:0]  TA_LAST    = 6'h01;   // Two turnaround bits
  localparam logic [5:0]  DATA_LAST  = 6'h0f;   // Sixteen data bits

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [4:0]  OFF_TENBASE   = 5'h12;
  localparam logic [4:0]  OFF_EXT_A     = 5'h13;
  localparam logic [4:0]  OFF_EXT_B     = 5'h14;
  localparam logic [4:0]  OFF_NEW_BASE  = 5'h15;  // Bank 0 words above ext B
  localparam logic [4:0]  OFF_VEND_BASE = 5'h14;  // Bank 1 vendor words
  localparam int          NEW_DEPTH     = 11;
  localparam int          VEND_DEPTH    = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TEN_POL_INH   = 3;
  localparam int TEN_SQE_INH   = 2;
  localparam int TEN_LINK_INH  = 1;
  localparam int TEN_SQL_INH   = 0;
  localparam int TEN_JAB_INH   = 5;
  localparam int EXA_NODE      = 15;
  localparam int EXA_SPD_SRC   = 14;
  localparam int EXA_RFAULT    = 13;
  localparam int EXA_BANK_HI   = 12;
  localparam int EXA_BANK_LO   = 11;
  localparam int EXA_XOVER_EN  = 9;
  localparam int EXA_PAIR_MAN  = 8;
  localparam int EXA_TP_TRI    = 7;
  localparam int EXA_AUTO_PD   = 0;
  localparam logic [1:0] BANK_VENDOR = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and writable masks
  localparam logic [15:0] TEN_RESET   = 16'h0010;
  localparam logic [15:0] TEN_WR_MASK = 16'h003f;
  localparam logic [15:0] EXA_RESET   = 16'h0201;
  localparam logic [15:0] EXA_WR_MASK = 16'hdbff;
  localparam logic [15:0] EXB_RESET   = 16'h3fe9;
  localparam logic [15:0] ARR_RESET   = 16'h0000;
  localparam logic [15:0] UNMAPPED    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        wr;      // One-cycle write strobe
    logic [4:0]  addr;    // Register address of the frame
    logic [15:0] data;    // Write data
  } pxc_req_type;

  typedef struct packed {
    logic        polarityCorrectEn;
    logic        sqeTestInhibit;
    logic        linkLossInhibit;
    logic        squelchInhibit;
    logic        jabberInhibit;
    logic        repeaterMode;
    logic        speedFromPin;
    logic        lineTristateEnable;
    logic        autoCrossoverEnable;
    logic        manualPairAssignment;
    logic        autoPowerDown;
    logic        bank1Selected;
    logic [15:0] ledCtrl;
  } pxc_ctrl_type;

endpackage : pxc_pkg

// ==== design/pxc_mdio_slave.sv ====
// Serial management frame engine: decodes preamble, start, opcode,
// addresses, turnaround and data, and drives read data back.
// Assumes MDC is synchronous to sys_clk and much slower than it.
`timescale 1ns/1ps
module pxc_mdio_slave (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic               mdc,
  input  wire logic               mdioIn,
  input  wire logic [4:0]         phyAddr,
  input  wire logic [15:0]        rdData,
  output logic                    mdioOut,
  output logic                    mdioOe,
  output pxc_pkg::pxc_req_type    req
);

  typedef enum logic [2:0] {S_PRE, S_ST, S_OP, S_ADR, S_TA, S_DAT} pxc_state_type;

  pxc_state_type state_reg;
  logic          mdcPrev_reg;
  logic [5:0]    cnt_reg;
  logic [15:0]   sh_reg;
  logic [15:0]   rdSh_reg;
  logic          isRead_reg;
  logic [4:0]    addr_reg;
  logic          wr_reg;
  logic [15:0]   wrData_reg;
  logic          out_reg;
  logic          oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of the sampled bits
  wire logic        mdcRise   = mdc & ~mdcPrev_reg;
  wire logic [11:0] frame     = {sh_reg[10:0], mdioIn};
  wire logic [1:0]  frameOp   = frame[11:10];
  wire logic        phyMatch  = frame[9:5] == phyAddr;
  wire logic        opValid   = (frameOp == pxc_pkg::OP_READ) | (frameOp == pxc_pkg::OP_WRITE);
  wire logic [5:0]  cntInc    = cnt_reg + 6'h01;
  wire logic [15:0] shNext    = {sh_reg[14:0], mdioIn};

  // Outputs straight from flip-flops
  assign mdioOut  = out_reg;
  assign mdioOe   = oe_reg;
  assign req.wr   = wr_reg;
  assign req.addr = addr_reg;
  assign req.data = wrData_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer, advancing on each MDC rising edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg   <= S_PRE;
      mdcPrev_reg <= 1'b0;
      cnt_reg     <= 6'h00;
      sh_reg      <= 16'h0000;
      rdSh_reg    <= 16'h0000;
      isRead_reg  <= 1'b0;
      addr_reg    <= 5'h00;
      wr_reg      <= 1'b0;
      wrData_reg  <= 16'h0000;
      out_reg     <= 1'b0;
      oe_reg      <= 1'b0;
    end else begin
      mdcPrev_reg <= mdc;
      wr_reg      <= 1'b0;
      if (mdcRise) begin
        case (state_reg)
          S_PRE: begin
            // Any zero before a full preamble restarts the count
            if (mdioIn) begin
              cnt_reg <= (cnt_reg == pxc_pkg::PRE_LEN) ? cnt_reg : cntInc;
            end else if (cnt_reg == pxc_pkg::PRE_LEN) begin
              state_reg <= S_ST;
              cnt_reg   <= 6'h00;
            end else begin
              cnt_reg <= 6'h00;
            end
          end
          S_ST: begin
            state_reg <= mdioIn ? S_OP : S_PRE;
          end
          S_OP: begin
            sh_reg    <= shNext;
            cnt_reg   <= (cnt_reg == pxc_pkg::OP_LAST) ? 6'h00 : cntInc;
            state_reg <= (cnt_reg == pxc_pkg::OP_LAST) ? S_ADR : S_OP;
          end
          S_ADR: begin
            sh_reg  <= shNext;
            cnt_reg <= cntInc;
            if (cnt_reg == pxc_pkg::ADR_LAST) begin
              // Frames for another address are ignored until next preamble
              cnt_reg    <= 6'h00;
              isRead_reg <= frameOp == pxc_pkg::OP_READ;
              addr_reg   <= frame[4:0];
              state_reg  <= (phyMatch & opValid) ? S_TA : S_PRE;
            end
          end
          S_TA: begin
            cnt_reg <= cntInc;
            if (cnt_reg != pxc_pkg::TA_LAST) begin
              // Drive the zero turnaround bit and capture read data
              oe_reg   <= isRead_reg;
              out_reg  <= 1'b0;
              rdSh_reg <= rdData;
            end else begin
              cnt_reg   <= 6'h00;
              state_reg <= S_DAT;
              out_reg   <= rdSh_reg[15];
              rdSh_reg  <= {rdSh_reg[14:0], 1'b0};
            end
          end
          S_DAT: begin
            cnt_reg  <= cntInc;
            sh_reg   <= shNext;
            out_reg  <= rdSh_reg[15];
            rdSh_reg <= {rdSh_reg[14:0], 1'b0};
            if (cnt_reg == pxc_pkg::DATA_LAST) begin
              cnt_reg    <= 6'h00;
              state_reg  <= S_PRE;
              oe_reg     <= 1'b0;
              wr_reg     <= ~isRead_reg;
              wrData_reg <= shNext;
            end
          end
          default: begin
            state_reg <= S_PRE;
          end
        endcase
      end
    end
  end

endmodule : pxc_mdio_slave

// ==== tb/pxc_ext_ctrl_regs_chk.sv ====
// Checker for the extended control bank: outputs tied to their causes.
// Assumes it is bound to pxc_ext_ctrl_regs, one sys_clk domain.
`timescale 1ns/1ps
module pxc_ext_ctrl_regs_chk (
  input wire logic             sys_clk,
  input wire logic             nrst,
  input wire logic             mdc,
  input wire logic             mdioOut,
  input wire logic             mdioOe,
  input wire logic             nodeStrap,
  input wire logic             speedStrap,
  input wire logic             speedPin,
  input wire logic             ctrlSpeedBit,
  input wire logic             linkTestOk,
  input wire logic             rxPolReversed,
  input wire logic             rxData10,
  input wire logic             rxData10Fixed,
  input wire logic             link10Pass,
  input wire logic             tpOutEn,
  input wire logic             speed100,
  input pxc_pkg::pxc_ctrl_type ctrlOut
);
  // Every output is one register stage after its cause
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////
  a_pol_fix: assert property ($past(nrst) |-> rxData10Fixed ==
    ($past(rxData10) ^ ($past(rxPolReversed) & ctrlOut.polarityCorrectEn)))
    else $error("receive polarity correction wrong");
  a_link_force: assert property ($past(nrst) |->
    link10Pass == ($past(linkTestOk) | ctrlOut.linkLossInhibit))
    else $error("link pass not forced by inhibit");
  a_speed_src: assert property ($past(nrst) |-> speed100 ==
    (ctrlOut.speedFromPin ? $past(speedPin) : $past(ctrlSpeedBit)))
    else $error("speed source selection wrong");
  // Straps land on the first edge after release, so the copy shows them one edge later
  a_strap_load: assert property ($past(nrst, 2) && !$past(nrst, 3) |->
    ctrlOut.speedFromPin == $past(speedStrap) && ctrlOut.repeaterMode == $past(nodeStrap))
    else $error("straps not loaded after reset");
  a_line_tri: assert property ($past(nrst) |-> tpOutEn == !ctrlOut.lineTristateEnable)
    else $error("line drivers not released by tri-state");
  // Copy register is zero in reset and takes the field reset values one edge after release
  a_reset_vals: assert property ($past(nrst) && !$past(nrst, 2) |->
    ctrlOut.autoCrossoverEnable &&
    ctrlOut.autoPowerDown && ctrlOut.polarityCorrectEn && !ctrlOut.manualPairAssignment &&
    !ctrlOut.lineTristateEnable && !ctrlOut.linkLossInhibit && !ctrlOut.bank1Selected)
    else $error("control fields not at reset values");
  a_ta_zero: assert property ($rose(mdioOe) |-> !mdioOut)
    else $error("turnaround bit not driven low");
  a_out_steady: assert property (!mdc && !$past(mdc) |-> $stable(mdioOut) && $stable(mdioOe))
    else $error("read data moved without clock rise");
endmodule : pxc_ext_ctrl_regs_chk

bind pxc_ext_ctrl_regs pxc_ext_ctrl_regs_chk u_pxc_ext_ctrl_regs_chk (
  .sys_clk(sys_clk), .nrst(nrst), .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe),
  .nodeStrap(nodeStrap), .speedStrap(speedStrap), .speedPin(speedPin),
  .ctrlSpeedBit(ctrlSpeedBit), .linkTestOk(linkTestOk), .rxPolReversed(rxPolReversed),
  .rxData10(rxData10), .rxData10Fixed(rxData10Fixed), .link10Pass(link10Pass),
  .tpOutEn(tpOutEn), .speed100(speed100), .ctrlOut(ctrlOut));

// ==== tb/pxc_sta_model.sv ====
// Station management model: one full MDC/MDIO frame per call.
// Assumes the bench resolves the shared wire with a pull-up.
`timescale 1ns/1ps
module pxc_sta_model (
  input  wire logic sys_clk,
  input  wire logic mdioLine,
  output logic      mdc,
  output logic      staBit,
  output logic      staOe
);
  int halfCycles = 2;  // Bench slows the bus for some frames

  // MDC stands low and the wire is released between frames
  initial begin
    mdc = 1'b0;
    staBit = 1'b1;
    staOe = 1'b0;
  end

  ////////////////////////////////////////
  // Full preamble every frame, since the device has no suppression
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] fr;
    fr = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      mdc <= 1'b0;
      staBit <= fr[63 - i];
      staOe <= !(op == pxc_pkg::OP_READ && i >= 46);  // Let go from turnaround on
      repeat (halfCycles) @(negedge sys_clk);
      if (i >= 48) rd = {rd[14:0], mdioLine};  // Taken at the rise
      mdc <= 1'b1;
      repeat (halfCycles - 1) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    mdc <= 1'b0;
    staOe <= 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask : xfer
endmodule : pxc_sta_model

// ==== tb/phy_extended_control_regs_test.sv ====
// Self-checking bench for the extended control bank over MDC/MDIO.
// Assumes pxc_sta_model as master and a pulled-up shared wire.
`timescale 1ns/1ps
module phy_extended_control_regs_test;
  logic                  sys_clk, nrst, mdc, staBit, staOe, mdioOut, mdioOe;
  logic                  nodeStrap, speedStrap, speedPin, ctrlSpeedBit, remoteFault;
  logic                  linkTestOk, rxPolReversed, rxData10;
  logic                  rxData10Fixed, link10Pass, tpOutEn, speed100;
  logic [4:0]            phyAddr;
  pxc_pkg::pxc_ctrl_type ctrlOut;
  wire logic             mdioLine;
  logic [15:0]           m0 [32];  // Bank 0 view, vendor words apart
  logic [15:0]           m1 [32];
  int                    n_errors = 0;
  int                    checks = 0;

  // Wire level from both drivers, pull-up when idle
  assign mdioLine = mdioOe ? mdioOut : (staOe ? staBit : 1'b1);

  pxc_ext_ctrl_regs u_pxc_ext_ctrl_regs (
    .sys_clk(sys_clk), .nrst(nrst), .mdc(mdc), .mdioIn(mdioLine), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .phyAddr(phyAddr), .nodeStrap(nodeStrap), .speedStrap(speedStrap),
    .speedPin(speedPin), .ctrlSpeedBit(ctrlSpeedBit), .remoteFault(remoteFault),
    .linkTestOk(linkTestOk), .rxPolReversed(rxPolReversed), .rxData10(rxData10),
    .rxData10Fixed(rxData10Fixed), .link10Pass(link10Pass), .tpOutEn(tpOutEn),
    .speed100(speed100), .ctrlOut(ctrlOut));
  pxc_sta_model u_pxc_sta_model (
    .sys_clk(sys_clk), .mdioLine(mdioLine), .mdc(mdc), .staBit(staBit), .staOe(staOe));

  ////////////////////////////////////////
  // 25 MHz clock, live inputs toggled at random every cycle
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    {speedPin, ctrlSpeedBit, linkTestOk, rxPolReversed, rxData10} <= 5'($urandom);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  // Reference register file, written from the bit tables
  function automatic logic [15:0] mdl_rd(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == pxc_pkg::OFF_TENBASE) v = m0[a];
    else if (a == pxc_pkg::OFF_EXT_A) v = {m0[a][15:14], remoteFault, m0[a][12:0]};
    else if (a >= pxc_pkg::OFF_EXT_B) v = (m0[5'h13][12:11] == 2'h1) ? m1[a] : m0[a];
    return v;
  endfunction : mdl_rd

  task automatic mdl_wr(input logic [4:0] a, input logic [15:0] d);
    if (a == pxc_pkg::OFF_TENBASE) m0[a] = (m0[a] & 16'hffc0) | (d & 16'h003f);
    else if (a == pxc_pkg::OFF_EXT_A) m0[a] = (m0[a] & 16'h2400) | (d & 16'hdbff);
    else if (a >= pxc_pkg::OFF_EXT_B && m0[5'h13][12:11] == 2'h1) m1[a] = d;
    else if (a >= pxc_pkg::OFF_EXT_B) m0[a] = d;
  endtask : mdl_wr

  task automatic chk_ctrl();
    logic [15:0] t, x, got, want;
    t = m0[5'h12];
    x = m0[5'h13];
    got = {4'h0, ctrlOut.repeaterMode, ctrlOut.jabberInhibit, ctrlOut.sqeTestInhibit,
           ctrlOut.squelchInhibit, ctrlOut.polarityCorrectEn, ctrlOut.linkLossInhibit,
           ctrlOut.speedFromPin,
           ctrlOut.lineTristateEnable, tpOutEn, ctrlOut.autoCrossoverEnable,
           ctrlOut.manualPairAssignment, ctrlOut.autoPowerDown};
    want = {4'h0, x[15], t[5], t[2], t[0], ~t[3], t[1], x[14], x[7], ~x[7], x[9], x[8], x[0]};
    chk(got, want);
    chk({15'h0000, ctrlOut.bank1Selected}, {15'h0000, x[12:11] == 2'h1});
    chk(ctrlOut.ledCtrl, m0[5'h14]);
  endtask : chk_ctrl

  // One frame, then reference update and comparison
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] a,
                       input logic [15:0] d);
    logic [15:0] rd;
    u_pxc_sta_model.xfer(op, phy, a, d, rd);
    if (phy == phyAddr && op == pxc_pkg::OP_READ) chk(rd, mdl_rd(a));
    if (phy == phyAddr && op == pxc_pkg::OP_WRITE) mdl_wr(a, d);
    chk_ctrl();
  endtask : frame

  // Straps are random and held steady across the release
  task automatic do_reset();
    nrst <= 1'b0;
    {nodeStrap, speedStrap} <= 2'($urandom);
    repeat (16) @(negedge sys_clk);
    for (int i = 0; i < 32; i++) begin
      m0[i] = 16'h0000;
      m1[i] = 16'h0000;
    end
    m0[5'h12] = pxc_pkg::TEN_RESET;
    m0[5'h13] = pxc_pkg::EXA_RESET | {nodeStrap, speedStrap, 14'h0000};
    m0[5'h14] = pxc_pkg::EXB_RESET;
    nrst <= 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : do_reset

  task automatic read_all();
    for (int a = 0; a < 32; a++) begin
      frame(pxc_pkg::OP_READ, phyAddr, 5'(a), 16'h0000);
    end
  endtask : read_all

  task automatic results();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////
  // Ext A is written in at least a quarter of the loop passes so bank flips happen often
  initial begin
    logic [4:0] a;
    logic [1:0] op;
    int         k;
    void'($urandom(90));
    nrst = 1'b0;
    phyAddr = 5'($urandom);
    {nodeStrap, speedStrap, remoteFault} = 3'h0;
    {speedPin, ctrlSpeedBit, linkTestOk, rxPolReversed, rxData10} = 5'h00;
    do_reset();
    read_all();
    for (int i = 0; i < 60; i++) begin
      u_pxc_sta_model.halfCycles = (i % 4 == 0) ? 5 : 2;
      remoteFault <= 1'($urandom);
      k = $urandom % 8;
      a = (k < 2) ? 5'h13 : 5'($urandom);
      op = (k >= 6) ? {2{k[0]}} : ((k == 3) ? pxc_pkg::OP_READ : pxc_pkg::OP_WRITE);
      frame(op, (k == 5) ? phyAddr ^ 5'h01 : phyAddr, a, 16'($urandom));
      frame(pxc_pkg::OP_READ, phyAddr, a, 16'h0000);
    end
    do_reset();
    read_all();
    results();
  end

  // Cut a hang short well past the expected run length
  initial begin
    #(40 * 100000);
    n_errors++;
    results();
  end
endmodule : phy_extended_control_regs_test
